/* verilog/ltc_pkg.sv */
// constants for the amplifier/termination and power control registers
package ltc_pkg;
  // register indices and their word-aligned byte addresses
  localparam logic [7:0] LTC_AMP_IDX = 8'hC4;
  localparam logic [7:0] LTC_PWR_IDX = 8'hC5;
  localparam int LTC_AW = 12;
  localparam logic [LTC_AW-1:0] LTC_AMP_ADDR = {2'h0, LTC_AMP_IDX, 2'h0};
  localparam logic [LTC_AW-1:0] LTC_PWR_ADDR = {2'h0, LTC_PWR_IDX, 2'h0};
  localparam int LTC_RW = 16;
  localparam logic [15:0] LTC_AMP_RST = 16'h0000;
  localparam logic [15:0] LTC_PWR_RST = 16'h0000;
  // amplifier configuration fields
  localparam int LTC_GAIN_IND_B = 15;
  localparam int LTC_GAIN_HI = 14;
  localparam int LTC_GAIN_LO = 13;
  localparam int LTC_HPF_OFF_B = 12;
  localparam int LTC_CLAMP_HI = 10;
  localparam int LTC_CLAMP_LO = 9;
  localparam int LTC_TERM_EN_B = 8;
  localparam int LTC_GTERM_HI = 7;
  localparam int LTC_GTERM_LO = 6;
  localparam int LTC_IND_EN_B = 5;
  localparam int LTC_IND_HI = 4;
  // power control fields
  localparam int LTC_FULL_PD_B = 15;
  localparam int LTC_QUICK_PD_B = 14;
  localparam int LTC_AMP_PD_B = 13;
  localparam int LTC_ATT_PD_B = 12;
  localparam int LTC_PMODE_HI = 11;
  localparam int LTC_PMODE_LO = 10;
  localparam int LTC_LNF_B = 9;
  localparam int LTC_PWR_ZERO_B = 8;
  localparam int LTC_PAIRS = 8;
  localparam logic [1:0] LTC_PMODE_LOW_NOISE = 2'h0;
  // gain codes and their values in dB
  localparam logic [1:0] LTC_GC_18 = 2'h0;
  localparam logic [1:0] LTC_GC_24 = 2'h1;
  localparam logic [1:0] LTC_GC_12 = 2'h2;
  localparam logic [4:0] LTC_DB_12 = 5'h0C;
  localparam logic [4:0] LTC_DB_18 = 5'h12;
  localparam logic [4:0] LTC_DB_24 = 5'h18;
  localparam logic [4:0] LTC_DB_NONE = 5'h00;
  // termination values are reported in hundredths of an ohm
  localparam int LTC_CW = 18;
  localparam int LTC_CENTI = 100;
  localparam logic [17:0] LTC_GT_50 = 18'h01388;
  localparam logic [17:0] LTC_GT_100 = 18'h02710;
  localparam logic [17:0] LTC_GT_200 = 18'h04E20;
  localparam logic [17:0] LTC_GT_400 = 18'h09C40;
  localparam logic [17:0] LTC_FRAC_6667 = 18'h01A0B;
  localparam logic [4:0] LTC_FRAC_CODE = 5'h06;
  typedef enum logic [1:0] {LTC_G12, LTC_G18, LTC_G24} ltc_gain_e;
endpackage

/* verilog/ltc_term_decode.sv */
// individual resistor code to termination value, per gain column
`timescale 1ns/100ps
module ltc_term_decode (
  input wire ltc_pkg::ltc_gain_e gain,
  input wire logic [4:0] code,
  output logic high_z,
  output logic [ltc_pkg::LTC_CW-1:0] centiohm
);
  import ltc_pkg::*;
  localparam int T12 [32] = '{0, 150, 300, 100, 600, 120, 200, 86,
    1200, 133, 240, 92, 400, 109, 171, 80, 1500, 136, 250, 94, 429, 111,
    176, 81, 667, 122, 207, 87, 316, 102, 154, 76};
  localparam int T18 [32] = '{0, 90, 180, 60, 360, 72, 120, 51,
    720, 80, 144, 55, 240, 65, 103, 48, 900, 82, 150, 56, 257, 67,
    106, 49, 400, 73, 124, 52, 189, 61, 92, 46};
  localparam int T24 [32] = '{0, 50, 100, 33, 200, 40, 67, 29,
    400, 44, 80, 31, 133, 36, 57, 27, 500, 45, 83, 31, 143, 37,
    59, 27, 222, 41, 69, 29, 105, 34, 51, 25};
  int ohms;

  always_comb begin
    ohms = T18[code];
    case (gain)
      LTC_G12: ohms = T12[code];
      LTC_G24: ohms = T24[code];
      default: ohms = T18[code];
    endcase
    high_z = (code == 5'h00); // [R10]
    centiohm = LTC_CW'(ohms * LTC_CENTI); // [R10]
    // the one fractional entry is kept exact
    if (gain == LTC_G24 && code == LTC_FRAC_CODE) begin
      centiohm = LTC_FRAC_6667;
    end
  end
endmodule

/* verilog/ltc_regs.sv */
// amplifier/termination and power control registers behind apb
//
// What this block does
// R1 - bit 15 selects per-channel gain control
// R2 - gain code: 00=18, 01=24, 10=12 dB
// R3 - bit 12 set turns highpass filter off
// R4 - clamp code: auto, 1.5, 1.15, 0.6 Vpp
// R5 - bit 8 enables active termination
// R6 - global termination 50/100/200/400 ohms
// R7 - at 12 dB code 00 is high-z
// R8 - bit 5 enables individual resistor control
// R9 - resistor code acts only when enabled
// R10 - resistor code and gain pick value; 00000=high-z
// R11 - power register layout, bit 8 zero
// R12 - amplifier register sits at C4h
// R13 - all fields reset to zero
// R14 - software writes zero to reserved bits
`timescale 1ns/100ps
module ltc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ltc_pkg::LTC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic per_channel_gain_enable,
  output logic [1:0] global_input_gain_code,
  output logic [4:0] input_gain_db,
  output logic input_highpass_off,
  output logic [1:0] input_clamp_level,
  output logic termination_enable,
  output logic [1:0] global_termination_code,
  output logic individual_resistor_enable,
  output logic [4:0] individual_resistor_code,
  output logic termination_high_z,
  output logic [ltc_pkg::LTC_CW-1:0] termination_centiohm,
  output logic full_power_down,
  output logic quick_wake_power_down,
  output logic amplifier_only_power_down,
  output logic attenuator_gain_stage_power_down,
  output logic [1:0] power_mode_select,
  output logic low_noise_figure_mode,
  output logic [ltc_pkg::LTC_PAIRS-1:0] channel_pair_power_down
);
  import ltc_pkg::*;

  logic [15:0] amp_q;
  logic [15:0] pwr_q;
  logic [4:0] gain_db_q;
  logic [4:0] gain_db_d;
  logic term_hz_q;
  logic term_hz_d;
  logic [LTC_CW-1:0] term_ohm_q;
  logic [LTC_CW-1:0] term_ohm_d;
  ltc_gain_e gain_col;
  logic ind_hz;
  logic [LTC_CW-1:0] ind_ohm;
  logic access;
  logic hit_amp;
  logic hit_pwr;
  logic wr_amp;
  logic wr_pwr;

  // zero wait states: every access completes in its first access cycle
  assign access = psel & penable;
  assign hit_amp = (paddr == LTC_AMP_ADDR); // [R12]
  assign hit_pwr = (paddr == LTC_PWR_ADDR);
  assign wr_amp = access & pwrite & hit_amp;
  assign wr_pwr = access & pwrite & hit_pwr;
  assign pready = 1'b1;
  assign pslverr = access & ~(hit_amp | hit_pwr);

  always_comb begin
    prdata = 32'h00000000;
    if (hit_amp) begin
      prdata = {16'h0000, amp_q};
    end else if (hit_pwr) begin
      prdata = {16'h0000, pwr_q};
    end
  end

  // amplifier register; reserved bit 11 is stored as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_q <= LTC_AMP_RST; // [R13]
    end else if (wr_amp) begin
      if (pstrb[1]) begin
        amp_q[15:8] <= pwdata[15:8]; // [R1] [R3] [R5]
      end
      if (pstrb[0]) begin
        amp_q[7:0] <= pwdata[7:0]; // [R6] [R8]
      end
    end
  end

  // power register; bit 8 is never stored so it always reads zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= LTC_PWR_RST; // [R13]
    end else if (wr_pwr) begin
      if (pstrb[1]) begin
        pwr_q[15:10] <= pwdata[15:10]; // [R11]
        // low noise figure only accepted while in low-noise mode
        if (pwr_q[LTC_PMODE_HI:LTC_PMODE_LO] == LTC_PMODE_LOW_NOISE) begin
          pwr_q[LTC_LNF_B] <= pwdata[LTC_LNF_B];
        end
        pwr_q[LTC_PWR_ZERO_B] <= 1'b0; // [R11]
      end
      if (pstrb[0]) begin
        pwr_q[7:0] <= pwdata[7:0]; // [R11]
      end
    end
  end

  // field outputs straight from the register flops; decoded gain and termination outputs from the decode flops
  assign per_channel_gain_enable = amp_q[LTC_GAIN_IND_B]; // [R1]
  assign global_input_gain_code = amp_q[LTC_GAIN_HI:LTC_GAIN_LO];
  assign input_highpass_off = amp_q[LTC_HPF_OFF_B]; // [R3]
  assign input_clamp_level = amp_q[LTC_CLAMP_HI:LTC_CLAMP_LO]; // [R4]
  assign termination_enable = amp_q[LTC_TERM_EN_B]; // [R5]
  assign global_termination_code = amp_q[LTC_GTERM_HI:LTC_GTERM_LO];
  assign individual_resistor_enable = amp_q[LTC_IND_EN_B]; // [R8]
  assign individual_resistor_code = amp_q[LTC_IND_HI:0];
  assign full_power_down = pwr_q[LTC_FULL_PD_B];
  assign quick_wake_power_down = pwr_q[LTC_QUICK_PD_B];
  assign amplifier_only_power_down = pwr_q[LTC_AMP_PD_B];
  assign attenuator_gain_stage_power_down = pwr_q[LTC_ATT_PD_B];
  assign power_mode_select = pwr_q[LTC_PMODE_HI:LTC_PMODE_LO];
  assign low_noise_figure_mode = pwr_q[LTC_LNF_B];
  assign channel_pair_power_down = pwr_q[LTC_PAIRS-1:0];
  assign input_gain_db = gain_db_q;
  assign termination_high_z = term_hz_q;
  assign termination_centiohm = term_ohm_q;

  // gain decode; the reserved code reports 0 dB and uses the 18 dB column
  always_comb begin
    gain_db_d = LTC_DB_NONE;
    gain_col = LTC_G18;
    case (global_input_gain_code)
      LTC_GC_18: begin
        gain_db_d = LTC_DB_18; // [R2]
        gain_col = LTC_G18;
      end
      LTC_GC_24: begin
        gain_db_d = LTC_DB_24; // [R2]
        gain_col = LTC_G24;
      end
      LTC_GC_12: begin
        gain_db_d = LTC_DB_12; // [R2]
        gain_col = LTC_G12;
      end
      default: begin
        gain_db_d = LTC_DB_NONE;
        gain_col = LTC_G18;
      end
    endcase
  end

  ltc_term_decode u_term_decode (
    .gain(gain_col),
    .code(individual_resistor_code),
    .high_z(ind_hz),
    .centiohm(ind_ohm)
  );

  // termination selection: disabled, individual, or global mapping
  always_comb begin
    term_hz_d = 1'b1;
    term_ohm_d = '0;
    if (!termination_enable) begin
      term_hz_d = 1'b1; // [R5]
      term_ohm_d = '0;
    end else if (individual_resistor_enable) begin
      term_hz_d = ind_hz; // [R9] [R10]
      term_ohm_d = ind_hz ? '0 : ind_ohm;
    end else begin
      term_hz_d = 1'b0;
      case (global_termination_code)
        2'h0: begin
          // 50 ohm cannot be built at 12 dB, falls back to high-z
          term_hz_d = (gain_col == LTC_G12); // [R7]
          term_ohm_d = (gain_col == LTC_G12) ? '0 : LTC_GT_50; // [R6]
        end
        2'h1: term_ohm_d = LTC_GT_100; // [R6]
        2'h2: term_ohm_d = LTC_GT_200; // [R6]
        default: term_ohm_d = LTC_GT_400; // [R6]
      endcase
    end
  end

  // decoded values are registered; they trail the register by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_db_q <= LTC_DB_NONE;
      term_hz_q <= 1'b1;
      term_ohm_q <= '0;
    end else begin
      gain_db_q <= gain_db_d; // [R2]
      term_hz_q <= term_hz_d; // [R7] [R10]
      term_ohm_q <= term_ohm_d; // [R6]
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  logic [15:0] prdata_amp_now;
  assign prdata_amp_now = amp_q;

  sequence apb_setup_s(logic [LTC_AW-1:0] a);
    psel && !penable && pwrite && paddr == a && pstrb[1:0] == 2'h3;
  endsequence

  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  amp_write_lands_a: assert property ( // [R12]
    apb_setup_s(LTC_AMP_ADDR) ##1 apb_access_s |=>
      prdata_amp_now == $past(pwdata[15:0]))
    else $error("amplifier register write not stored");

  gain_sel_bit_a: assert property ( // [R1]
    wr_amp && pstrb[1] |=> per_channel_gain_enable == $past(pwdata[15]))
    else $error("gain select bit not updated");

  gain_decode_a: assert property ( // [R2]
    global_input_gain_code == LTC_GC_12 |=> input_gain_db == 5'h0C)
    else $error("12 dB gain code decoded wrongly");

  // decode flop leaves reset with the register but holds 0 dB until one edge later
  gain_18_a: assert property ( // [R2]
    seen_q && global_input_gain_code == LTC_GC_18 |=>
      input_gain_db == 5'h12)
    else $error("18 dB gain code decoded wrongly");

  gain_24_a: assert property ( // [R2]
    seen_q && global_input_gain_code == LTC_GC_24 |=>
      input_gain_db == 5'h18)
    else $error("24 dB gain code decoded wrongly");

  highpass_bit_a: assert property ( // [R3]
    wr_amp && pstrb[1] |=> input_highpass_off == $past(pwdata[12]))
    else $error("highpass control not updated");

  clamp_field_a: assert property ( // [R4]
    wr_amp && pstrb[1] |=> input_clamp_level == $past(pwdata[10:9]))
    else $error("clamp level not updated");

  term_off_hz_a: assert property ( // [R5]
    !termination_enable ##1 !termination_enable |-> termination_high_z)
    else $error("termination active while disabled");

  global_400_a: assert property ( // [R6]
    termination_enable && !individual_resistor_enable &&
      global_termination_code == 2'h3 |=>
      !termination_high_z && termination_centiohm == 18'd40000)
    else $error("global 400 ohm termination wrong");

  hz_at_12db_a: assert property ( // [R7]
    termination_enable && !individual_resistor_enable &&
      global_termination_code == 2'h0 &&
      global_input_gain_code == LTC_GC_12 |=> termination_high_z)
    else $error("50 ohm selected at 12 dB gain");

  ind_ignored_a: assert property ( // [R9]
    termination_enable && !individual_resistor_enable &&
      global_termination_code == 2'h1 |=>
      termination_centiohm == 18'd10000)
    else $error("resistor code acted while disabled");

  ind_used_a: assert property ( // [R8]
    termination_enable && individual_resistor_enable &&
      individual_resistor_code == 5'h01 &&
      global_input_gain_code == LTC_GC_24 |=>
      termination_centiohm == 18'd5000)
    else $error("individual resistor code not applied");

  ind_zero_hz_a: assert property ( // [R10]
    termination_enable && individual_resistor_enable &&
      individual_resistor_code == 5'h00 |=> termination_high_z)
    else $error("resistor code zero not high-z");

  pwr_bit8_a: assert property ( // [R11]
    access && !pwrite && hit_pwr |-> prdata[8] == 1'b0)
    else $error("power register bit 8 not zero");

  term_en_bit_a: assert property ( // [R5]
    wr_amp && pstrb[1] |=> termination_enable == $past(pwdata[8]))
    else $error("termination enable not updated");

  gterm_field_a: assert property ( // [R6]
    wr_amp && pstrb[0] |=>
      global_termination_code == $past(pwdata[7:6]))
    else $error("global termination code not updated");

  global_50_a: assert property ( // [R6]
    termination_enable && !individual_resistor_enable &&
      global_termination_code == 2'h0 &&
      global_input_gain_code != LTC_GC_12 |=>
      !termination_high_z && termination_centiohm == 18'd5000)
    else $error("global 50 ohm termination wrong");

  global_200_a: assert property ( // [R6]
    termination_enable && !individual_resistor_enable &&
      global_termination_code == 2'h2 |=>
      !termination_high_z && termination_centiohm == 18'd20000)
    else $error("global 200 ohm termination wrong");

  ind_en_bit_a: assert property ( // [R8]
    wr_amp && pstrb[0] |=>
      individual_resistor_enable == $past(pwdata[5]))
    else $error("individual resistor enable not updated");

  ind_code_field_a: assert property ( // [R9]
    wr_amp && pstrb[0] |=>
      individual_resistor_code == $past(pwdata[4:0]))
    else $error("individual resistor code not updated");

  ind_12db_a: assert property ( // [R10]
    termination_enable && individual_resistor_enable &&
      individual_resistor_code == 5'h08 &&
      global_input_gain_code == LTC_GC_12 |=>
      !termination_high_z && termination_centiohm == 18'd120000)
    else $error("12 dB resistor column wrong");

  pwr_upper_a: assert property ( // [R11]
    wr_pwr && pstrb[1] |=>
      {full_power_down, quick_wake_power_down, amplifier_only_power_down,
      attenuator_gain_stage_power_down, power_mode_select} ==
      $past(pwdata[15:10]))
    else $error("power-down or mode bits not updated");

  pair_pd_a: assert property ( // [R11]
    wr_pwr && pstrb[0] |=>
      channel_pair_power_down == $past(pwdata[7:0]))
    else $error("channel pair power-down not updated");

  reset_zero_a: assert property ( // [R13]
    !seen_q |-> amp_q == 16'h0000 && pwr_q == 16'h0000)
    else $error("register not zero after reset");
endmodule

/* tb/ltc_regs_tb.sv */
// self-checking bench for the amplifier/termination and power registers
`timescale 1ns/100ps
module ltc_regs_tb;
  import ltc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [LTC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic gind, hpf, ten, ien, hz, fpd, qpd, apd, gpd, lnf;
  logic [1:0] gcode, clamp, tcode, pmode;
  logic [4:0] gdb, icode;
  logic [LTC_CW-1:0] cohm;
  logic [LTC_PAIRS-1:0] cpd;
  int bad_count, samples_checked;
  logic [4:0] db_tab [4] = '{LTC_DB_18, LTC_DB_24, LTC_DB_12, LTC_DB_18};
  logic [17:0] gt_tab [4] = '{LTC_GT_50, LTC_GT_100, LTC_GT_200, LTC_GT_400};
  logic [1:0] g_tab [4] = '{LTC_GC_18, LTC_GC_24, LTC_GC_12, LTC_GC_18};

  ltc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .per_channel_gain_enable(gind), .global_input_gain_code(gcode),
    .input_gain_db(gdb), .input_highpass_off(hpf),
    .input_clamp_level(clamp), .termination_enable(ten),
    .global_termination_code(tcode), .individual_resistor_enable(ien),
    .individual_resistor_code(icode), .termination_high_z(hz),
    .termination_centiohm(cohm), .full_power_down(fpd),
    .quick_wake_power_down(qpd), .amplifier_only_power_down(apd),
    .attenuator_gain_stage_power_down(gpd), .power_mode_select(pmode),
    .low_noise_figure_mode(lnf), .channel_pair_power_down(cpd));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [LTC_AW-1:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdchk(input string nm, input logic [LTC_AW-1:0] a,
             input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0, experr}, {31'h0, err});
  endtask

  // decoded outputs lag the register by one cycle, so settle two
  task settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // write amp register, then check readback and decoded termination
  task tcase(input logic [15:0] v, input logic [17:0] expc);
    apb(1'b1, LTC_AMP_ADDR, {16'h0, v}, 4'hF);
    settle();
    rdchk("amp readback", LTC_AMP_ADDR, {16'h0, v}, 1'b0);
    chk("high_z", {31'h0, expc == 18'h0}, {31'h0, hz});
    chk("centiohm", {14'h0, expc}, {14'h0, cohm});
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    presetn = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rdchk("amp reset", LTC_AMP_ADDR, 32'h0, 1'b0);
    rdchk("pwr reset", LTC_PWR_ADDR, 32'h0, 1'b0);
    chk("gain db reset", {27'h0, LTC_DB_18}, {27'h0, gdb});
    // gain codes 00/01/10, every clamp and global termination code; bit 11 kept 0
    for (int i = 0; i < 4; i++) begin
      tcase({1'b0, g_tab[i], i[0], 1'b0, i[1:0], 1'b1, i[1:0], 6'h00},
            gt_tab[i]);
      chk("gain db", {27'h0, db_tab[i]}, {27'h0, gdb});
      chk("clamp", {30'h0, i[1:0]}, {30'h0, clamp});
      chk("hpf off", {31'h0, i[0]}, {31'h0, hpf});
    end
    tcase(16'h9725, 18'd7200);
    chk("fields", 32'h0000_4F25,
        {gind, gcode, hpf, clamp, ten, tcode, ien, icode});
    tcase(16'h0141, LTC_GT_100);
    tcase(16'h0161, 18'd9000);
    tcase(16'h0160, 18'h0);
    tcase(16'h2126, LTC_FRAC_6667);
    tcase(16'h213F, 18'd2500);
    tcase(16'h4128, 18'd120000);
    tcase(16'h4100, 18'h0);
    tcase(16'h0040, 18'h0);
    // upper byte lane only
    apb(1'b1, LTC_AMP_ADDR, 32'h0000_D7FF, 4'h2);
    rdchk("lane write", LTC_AMP_ADDR, 32'h0000_D740, 1'b0);
    // unmapped address: refused, amp untouched
    apb(1'b1, 12'h318, 32'h0000_FFFF, 4'hF);
    rdchk("unmapped", 12'h318, 32'h0, 1'b1);
    rdchk("amp kept", LTC_AMP_ADDR, 32'h0000_D740, 1'b0);
    // power layout; low noise write needs stored mode 00
    apb(1'b1, LTC_PWR_ADDR, 32'h0000_FEFF, 4'hF);
    rdchk("pwr all", LTC_PWR_ADDR, 32'h0000_FEFF, 1'b0);
    settle();
    chk("pwr outs", 32'h0000_FEFF, {16'h0, fpd, qpd, apd, gpd, pmode, lnf,
        1'b0, cpd});
    apb(1'b1, LTC_PWR_ADDR, 32'h0000_0C00, 4'hF);
    rdchk("pwr mode 11", LTC_PWR_ADDR, 32'h0000_0E00, 1'b0);
    apb(1'b1, LTC_PWR_ADDR, 32'h0000_0000, 4'hF);
    rdchk("lnf gated", LTC_PWR_ADDR, 32'h0000_0200, 1'b0);
    apb(1'b1, LTC_PWR_ADDR, 32'h0000_0000, 4'hF);
    rdchk("lnf clear", LTC_PWR_ADDR, 32'h0, 1'b0);
    settle();
    chk("lnf out", 32'h0, {31'h0, lnf});
    // reset in mid-run must clear both registers again
    apb(1'b1, LTC_AMP_ADDR, 32'h0000_A5A5, 4'hF);
    apb(1'b1, LTC_PWR_ADDR, 32'h0000_30FF, 4'hF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rdchk("amp rerun", LTC_AMP_ADDR, 32'h0, 1'b0);
    rdchk("pwr rerun", LTC_PWR_ADDR, 32'h0, 1'b0);
    chk("hz rerun", 32'h1, {31'h0, hz});
    chk("gain db rerun", {27'h0, LTC_DB_18}, {27'h0, gdb});
    report_and_stop();
  end
endmodule
